// file: core/bfr_defines.svh
// Constants for the bus fault response selector: offsets, field positions, resets, timing.
// Assumes a single 125 MHz system clock.
`ifndef BFR_DEFINES_SVH
`define BFR_DEFINES_SVH

`define BFR_ADDR_SEL 8'hB0
`define BFR_ADDR_LO 8'hB1
`define BFR_ADDR_HI 8'hB2
`define BFR_ADDR_STAT 8'hD2

`define BFR_SEL_BIT 7
`define BFR_LO_IN_UV_POS 6
`define BFR_HI_OUT_OV_POS 0
`define BFR_HI_OUT_UV_POS 2
`define BFR_HI_IN_OV_POS 4
`define BFR_HI_IN_UV_POS 6
`define BFR_STAT_BASE 3

`define BFR_SEL_RST 1'h0
`define BFR_RESP_RST 8'h00
`define BFR_STAT_RST 8'h00

`define BFR_CODE_HIC 2'h1
`define BFR_CODE_LAT 2'h2

`define BFR_NUM_FAULTS 5
`define BFR_TIMER_W 26
`define BFR_HICCUP_MS 500
`define BFR_CLK_KHZ 125000
`define BFR_HICCUP_CYCLES (`BFR_HICCUP_MS * `BFR_CLK_KHZ)

`endif

// file: core/bfr_pkg.sv
// Types for the bus fault response selector.
// Assumes bfr_defines.svh is on the include path.
`default_nettype none
`include "bfr_defines.svh"

package bfr_pkg;

	typedef enum logic [2:0] {
		BFR_ST_RUN = 3'h1,
		BFR_ST_HIC = 3'h2,
		BFR_ST_LAT = 3'h4
	} bfr_state_e;

	typedef enum logic [2:0] {
		BFR_RSP_FLAG = 3'h1,
		BFR_RSP_HIC = 3'h2,
		BFR_RSP_LAT = 3'h4
	} bfr_resp_e;

	typedef struct packed {
		logic [`BFR_NUM_FAULTS-1:0] fault;
		logic [1:0] strap;
		logic pwm_en;
		logic dev_en;
	} bfr_pins_s;

	typedef struct packed {
		bfr_pins_s s1;
		bfr_pins_s s2;
		logic sel;
		logic [7:0] lo_resp;
		logic [7:0] hi_resp;
		logic [7:0] stat;
		bfr_state_e state;
		logic [`BFR_TIMER_W-1:0] timer;
		logic pwm_run;
		logic stat_n;
		logic [7:0] rdata;
		logic rvalid;
	} bfr_st_s;

endpackage

`default_nettype wire

// file: core/bfr_top.sv
// Fault response selection for five supervised bus faults, with its control registers.
// Assumes fault levels, strap and enables arrive asynchronously and are synchronised here.
`timescale 1ns/100ps
`default_nettype none
`include "bfr_defines.svh"

module bfr_top #(
	parameter int unsigned HICCUP_CYCLES = `BFR_HICCUP_CYCLES
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	// Fault levels: 0 low-bus in UV, 1 high-bus out OV, 2 out UV, 3 in OV, 4 in UV.
	input wire logic [`BFR_NUM_FAULTS-1:0] fault_in,
	input wire logic [1:0] mode_strap,
	input wire logic pwm_en,
	input wire logic dev_en,
	// Register port.
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// Outputs to the switching core and the pin.
	output logic pwm_run,
	output logic fault_status_out_n
);

	bfr_pkg::bfr_st_s r_q;
	bfr_pkg::bfr_st_s r_d;
	bfr_pkg::bfr_resp_e mode [`BFR_NUM_FAULTS];
	logic [2*`BFR_NUM_FAULTS-1:0] fields;
	logic [`BFR_NUM_FAULTS-1:0] faults;
	logic [7:0] stat_clr;
	logic any_lat;
	logic any_hic;
	logic en_all;

	function automatic bfr_pkg::bfr_resp_e resp_of(input logic [1:0] code);
		if (code == `BFR_CODE_HIC) begin
			return bfr_pkg::BFR_RSP_HIC;
		end else if (code == `BFR_CODE_LAT) begin
			return bfr_pkg::BFR_RSP_LAT;
		end
		return bfr_pkg::BFR_RSP_FLAG;
	endfunction

	always_comb begin
		r_d = r_q;
		r_d.s1 = '{fault: fault_in, strap: mode_strap, pwm_en: pwm_en, dev_en: dev_en};
		r_d.s2 = r_q.s1;
		faults = r_q.s2.fault;
		en_all = r_q.s2.pwm_en & r_q.s2.dev_en;
		fields = {r_q.hi_resp[`BFR_HI_IN_UV_POS +: 2], r_q.hi_resp[`BFR_HI_IN_OV_POS +: 2],
			r_q.hi_resp[`BFR_HI_OUT_UV_POS +: 2], r_q.hi_resp[`BFR_HI_OUT_OV_POS +: 2],
			r_q.lo_resp[`BFR_LO_IN_UV_POS +: 2]};
		any_lat = 1'b0;
		any_hic = 1'b0;
		for (int i = 0; i < `BFR_NUM_FAULTS; i++) begin
			mode[i] = resp_of(r_q.sel ? fields[2*i +: 2] : r_q.s2.strap);
			any_lat = any_lat | (faults[i] & (mode[i] == bfr_pkg::BFR_RSP_LAT));
			any_hic = any_hic | (faults[i] & (mode[i] == bfr_pkg::BFR_RSP_HIC));
		end

		stat_clr = 8'h00;
		if (reg_wr) begin
			unique case (reg_addr)
				`BFR_ADDR_SEL: r_d.sel = reg_wdata[`BFR_SEL_BIT];
				`BFR_ADDR_LO: r_d.lo_resp = reg_wdata;
				`BFR_ADDR_HI: r_d.hi_resp = reg_wdata;
				`BFR_ADDR_STAT: stat_clr = reg_wdata;
				default: ;
			endcase
		end
		r_d.stat = (r_q.stat & ~stat_clr) | {faults, 3'h0};

		unique case (r_q.state)
			bfr_pkg::BFR_ST_RUN: begin
				if (any_lat) begin
					r_d.state = bfr_pkg::BFR_ST_LAT;
				end else if (any_hic) begin
					r_d.state = bfr_pkg::BFR_ST_HIC;
					r_d.timer = '0;
				end
			end
			bfr_pkg::BFR_ST_HIC: begin
				if (any_lat) begin
					r_d.state = bfr_pkg::BFR_ST_LAT;
				end else if (any_hic) begin
					r_d.timer = '0;
				end else if (r_q.timer >= `BFR_TIMER_W'(HICCUP_CYCLES - 1)) begin
					r_d.state = bfr_pkg::BFR_ST_RUN;
				end else begin
					r_d.timer = r_q.timer + `BFR_TIMER_W'(1);
				end
			end
			bfr_pkg::BFR_ST_LAT: begin
				if (!en_all && !any_lat) begin
					r_d.state = bfr_pkg::BFR_ST_RUN;
				end
			end
			default: r_d.state = bfr_pkg::BFR_ST_LAT;
		endcase
		r_d.pwm_run = (r_d.state == bfr_pkg::BFR_ST_RUN) & en_all;
		r_d.stat_n = ~|r_d.stat;

		r_d.rvalid = reg_rd;
		r_d.rdata = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				`BFR_ADDR_SEL: r_d.rdata = {r_q.sel, 7'h00};
				`BFR_ADDR_LO: r_d.rdata = r_q.lo_resp;
				`BFR_ADDR_HI: r_d.rdata = r_q.hi_resp;
				`BFR_ADDR_STAT: r_d.rdata = r_q.stat;
				default: r_d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			r_q <= '{s1: '0, s2: '0, sel: `BFR_SEL_RST, lo_resp: `BFR_RESP_RST,
				hi_resp: `BFR_RESP_RST, stat: `BFR_STAT_RST, state: bfr_pkg::BFR_ST_RUN,
				timer: '0, pwm_run: 1'b0, stat_n: 1'b1, rdata: 8'h00, rvalid: 1'b0};
		end else begin
			r_q <= r_d;
		end
	end

	assign reg_rdata = r_q.rdata;
	assign reg_rvalid = r_q.rvalid;
	assign pwm_run = r_q.pwm_run;
	assign fault_status_out_n = r_q.stat_n;

	sel_field_a: assert property (@(posedge clk) disable iff (!arst_n)
		r_q.sel && r_q.lo_resp[7:6] == 2'h2 && faults[0] |=> r_q.state == bfr_pkg::BFR_ST_LAT)
		else $error("Register field latch-off not taken.");

	strap_sel_a: assert property (@(posedge clk) disable iff (!arst_n)
		!r_q.sel && r_q.s2.strap == 2'h1 && faults == 5'h01 && r_q.state == bfr_pkg::BFR_ST_RUN
		|=> r_q.state == bfr_pkg::BFR_ST_HIC)
		else $error("Strap hiccup not taken.");

	lo_decode_a: assert property (@(posedge clk) disable iff (!arst_n)
		r_q.sel && r_q.lo_resp[7:6] == 2'h3 && faults == 5'h01 && en_all
		&& r_q.state == bfr_pkg::BFR_ST_RUN |=> r_q.pwm_run)
		else $error("Code 11 did not act as flag only.");

	lo_status_a: assert property (@(posedge clk) disable iff (!arst_n)
		faults[0] |=> r_q.stat[3] && !fault_status_out_n)
		else $error("Low-bus undervoltage not flagged.");

	hiccup_stop_a: assert property (@(posedge clk) disable iff (!arst_n)
		(any_hic || any_lat) |=> !r_q.pwm_run)
		else $error("Switching ran during a hiccup fault.");

	latch_stop_a: assert property (@(posedge clk) disable iff (!arst_n)
		any_lat |=> r_q.state == bfr_pkg::BFR_ST_LAT && !r_q.pwm_run)
		else $error("Latch-off fault did not stop switching.");

	flag_run_a: assert property (@(posedge clk) disable iff (!arst_n)
		en_all && r_q.state == bfr_pkg::BFR_ST_RUN && !any_hic && !any_lat
		|=> r_q.pwm_run)
		else $error("Flag-only fault stopped switching.");

	stat_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
		reg_wr && reg_addr == `BFR_ADDR_STAT && reg_wdata[`BFR_STAT_BASE] && !faults[0]
		|=> !r_q.stat[`BFR_STAT_BASE])
		else $error("Low-bus undervoltage status did not clear.");

	out_uv_stat_a: assert property (@(posedge clk) disable iff (!arst_n)
		faults[2] |=> r_q.stat[5])
		else $error("High-bus output undervoltage not flagged.");

	in_ov_stat_a: assert property (@(posedge clk) disable iff (!arst_n)
		faults[3] |=> r_q.stat[6])
		else $error("High-bus input overvoltage not flagged.");

	hiccup_end_a: assert property (@(posedge clk) disable iff (!arst_n)
		r_q.state == bfr_pkg::BFR_ST_HIC && !any_hic && !any_lat
		&& r_q.timer == `BFR_TIMER_W'(HICCUP_CYCLES - 1) |=> r_q.state == bfr_pkg::BFR_ST_RUN)
		else $error("Hiccup did not restart on time.");

	latch_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
		r_q.state == bfr_pkg::BFR_ST_LAT && en_all |=> r_q.state == bfr_pkg::BFR_ST_LAT && !pwm_run)
		else $error("Latch-off released without enable toggle.");

	hi_reg_a: assert property (@(posedge clk) disable iff (!arst_n)
		reg_wr && reg_addr == `BFR_ADDR_HI ##1 !reg_wr ##1 reg_rd && reg_addr == `BFR_ADDR_HI
		|=> reg_rdata == $past(reg_wdata, 3) && reg_rvalid)
		else $error("High-bus register readback wrong.");

	hi_ov_stat_a: assert property (@(posedge clk) disable iff (!arst_n)
		faults[1] |=> r_q.stat[4])
		else $error("High-bus overvoltage not flagged.");

	status_pin_a: assert property (@(posedge clk) disable iff (!arst_n)
		fault_status_out_n == (r_q.stat == 8'h00))
		else $error("Status output disagrees with status bits.");

endmodule

`default_nettype wire

// file: dv/bfr_host.sv
// Management-side controller model: single-byte register writes and reads.
// Assumes the one-cycle strobe register port of the selector.
`timescale 1ns/100ps
`default_nettype none
module bfr_host (
	// Clock.
	input wire logic clk,
	// Register port.
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	initial begin
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		reg_wr = 1'h1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk);
		#1;
		reg_wr = 1'h0;
		reg_wdata = ~d;
	endtask
	// Data without the valid pulse reads as unknown so it can never match.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		reg_rd = 1'h1;
		reg_addr = a;
		@(posedge clk);
		#1;
		reg_rd = 1'h0;
		d = reg_rvalid ? reg_rdata : 8'hXX;
	endtask
endmodule
`default_nettype wire

// file: dv/bfr_top_tb_top.sv
// Testbench for the fault response selector: every code, every fault, both selector settings.
// Assumes the host model drives the register port.
`timescale 1ns/100ps
`default_nettype none
`include "bfr_defines.svh"
module bfr_top_tb_top;
	localparam int unsigned HC = 20;
	logic clk, arst_n, pwm_en, dev_en, reg_wr, reg_rd, reg_rvalid, pwm_run, fault_status_out_n;
	logic [4:0] fault_in;
	logic [1:0] mode_strap, code;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rb;
	int bad_count, tests_run, s, c, i;
	bfr_top #(.HICCUP_CYCLES(HC)) dut (.clk(clk), .arst_n(arst_n), .fault_in(fault_in),
		.mode_strap(mode_strap), .pwm_en(pwm_en), .dev_en(dev_en), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .pwm_run(pwm_run), .fault_status_out_n(fault_status_out_n));
	bfr_host host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Raises one fault, then checks switching during, after, and once enables are toggled.
	task automatic fire(input int f, input logic r_on, input logic r_off);
		fault_in[f] = 1'h1;
		cyc(6);
		chk("status_n", 8'h00, {7'h00, fault_status_out_n});
		chk("pwm_run", {7'h00, r_on}, {7'h00, pwm_run});
		host.rd(`BFR_ADDR_STAT, rb);
		chk("status", 8'h01 << (f + 3), rb);
		fault_in[f] = 1'h0;
		cyc(HC);
		chk("pwm_hold", {7'h00, r_on}, {7'h00, pwm_run});
		cyc(2);
		chk("pwm_after", {7'h00, r_off}, {7'h00, pwm_run});
		chk("status_n_sticky", 8'h00, {7'h00, fault_status_out_n});
		{pwm_en, dev_en} = f[0] ? 2'h1 : 2'h2;
		cyc(4);
		{pwm_en, dev_en} = 2'h3;
		host.wr(`BFR_ADDR_STAT, 8'hFF);
		cyc(6);
		chk("status_n_clear", 8'h01, {7'h00, fault_status_out_n});
		chk("pwm_resume", 8'h01, {7'h00, pwm_run});
	endtask
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		give_verdict();
	end
	initial begin
		arst_n = 1'h0;
		fault_in = 5'h00;
		mode_strap = 2'h0;
		pwm_en = 1'h1;
		dev_en = 1'h1;
		repeat (8) @(posedge clk);
		#1;
		arst_n = 1'h1;
		cyc(4);
		host.rd(`BFR_ADDR_HI, rb);
		chk("hi_reset", 8'h00, rb);
		host.rd(8'h55, rb);
		chk("unmapped", 8'h00, rb);
		host.wr(`BFR_ADDR_HI, 8'hA5);
		host.rd(`BFR_ADDR_HI, rb);
		chk("hi_rw", 8'hA5, rb);
		$display("test registers done");
		for (s = 0; s < 2; s++) begin
			host.wr(`BFR_ADDR_SEL, s ? 8'h80 : 8'h00);
			for (c = 0; c < 4; c++) begin
				code = c[1:0];
				mode_strap = s ? `BFR_CODE_LAT : code;
				host.wr(`BFR_ADDR_LO, s ? {code, 6'h00} : 8'h80);
				host.wr(`BFR_ADDR_HI, s ? {4{code}} : 8'hAA);
				for (i = 0; i < 5; i++) begin
					fire(i, code == 2'h0 || code == 2'h3, code != 2'h2);
				end
			end
			$display("test selector %0d done", s);
		end
		host.rd(`BFR_ADDR_SEL, rb);
		chk("sel_rw", 8'h80, rb);
		arst_n = 1'h0;
		cyc(2);
		chk("status_n_rst", 8'h01, {7'h00, fault_status_out_n});
		arst_n = 1'h1;
		cyc(4);
		host.rd(`BFR_ADDR_HI, rb);
		chk("hi_rst_again", 8'h00, rb);
		host.rd(`BFR_ADDR_SEL, rb);
		chk("sel_rst", 8'h00, rb);
		chk("pwm_rst_resume", 8'h01, {7'h00, pwm_run});
		$display("test mid-run reset done");
		give_verdict();
	end
endmodule
`default_nettype wire
